// ===== asm_map.svh
// constants of the axis speed plausibility monitor
`ifndef ASM_MAP_SVH
`define ASM_MAP_SVH

// clock rate in kHz, so milliseconds times this gives cycles
`define ASM_CLK_KHZ       100000
// number of monitored axes
`define ASM_AXES          2
// pulse silence after which an input counts as inactive, ms
`define ASM_ACT_WIN_MS    10000
// direction distrust window after an error, ms
`define ASM_DIR_HOLD_MS   500
// indicator blink period, ms
`define ASM_BLINK_PER_MS  1000
// on time of a brief flash, ms
`define ASM_BRIEF_ON_MS   100
// cycle counts derived from the times above
`define ASM_ACT_WIN_CYC   (`ASM_ACT_WIN_MS * `ASM_CLK_KHZ)
`define ASM_DIR_HOLD_CYC  (`ASM_DIR_HOLD_MS * `ASM_CLK_KHZ)
`define ASM_BLINK_PER_CYC (`ASM_BLINK_PER_MS * `ASM_CLK_KHZ)
`define ASM_BRIEF_ON_CYC  (`ASM_BRIEF_ON_MS * `ASM_CLK_KHZ)
// reset value of every state bit
`define ASM_RST_VAL       '0

`endif

// ===== asm_pkg.sv
// types shared by the axis speed plausibility monitor
package asm_pkg;

  // plausibility case of one axis
  typedef enum logic [3:0] {
    PL_STILL,
    PL_PROX_ONLY,
    PL_SHEAR_BROKEN,
    PL_B_ONLY,
    PL_A_LOST,
    PL_A_ONLY,
    PL_B_LOST,
    PL_PROX_LOST,
    PL_ROTATE
  } asm_case_t;

  // system operating state
  typedef enum logic [1:0] {
    SYS_LOAD,
    SYS_RUN,
    SYS_SAFE
  } asm_sys_t;

  // outputs and diagnostics of one axis
  typedef struct packed {
    logic standstill;
    logic speed_ok;
    logic diag_prox;
    logic diag_enc;
    logic diag_freq;
    logic err_entry;
  } asm_axis_out_t;

  // state of one pulse activity detector
  typedef struct packed {
    logic        prev;
    logic [31:0] cnt;
    logic        active;
  } asm_act_st_t;

  // whole state of the monitor
  typedef struct packed {
    asm_sys_t                 sys;
    asm_case_t [1:0]          cls;
    asm_axis_out_t [1:0]      axis;
    logic [1:0]               err_push;
    logic [1:0][31:0]         dir_cnt;
    logic [1:0]               dir_valid;
    logic [31:0]              blink_cnt;
    logic                     ready_led;
    logic                     fault_led;
    logic [1:0]               axis_led;
    logic [1:0]               enc_led;
    logic [3:0]               prox_led;
  } asm_mon_st_t;

endpackage

// ===== asm_act_det.sv
// pulse activity detector: high while edges keep arriving
`timescale 1ns/1ps
`default_nettype none
`include "asm_map.svh"

module asm_act_det
  import asm_pkg::*;
#(
  parameter int unsigned WIN_CYC = `ASM_ACT_WIN_CYC
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic PULSE_IN,
  output logic      ACTIVE
);

  asm_act_st_t st_r;
  asm_act_st_t st_nxt;

  // edge retriggers the silence window
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = PULSE_IN;
    if (PULSE_IN != st_r.prev) begin
      st_nxt.cnt    = 32'(WIN_CYC);
      st_nxt.active = 1'b1;
    end else if (st_r.cnt != 32'h0) begin
      st_nxt.cnt = st_r.cnt - 32'h1;
    end else begin
      st_nxt.active = 1'b0;
    end
  end

  // state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= `ASM_RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ACTIVE = st_r.active;

endmodule
`default_nettype wire

// ===== asm_monitor.sv
// two-axis speed plausibility monitor with outputs, diagnostics and indicators
`timescale 1ns/1ps
`default_nettype none
`include "asm_map.svh"

module asm_monitor
  import asm_pkg::*;
#(
  parameter int unsigned ACT_WIN_CYC   = `ASM_ACT_WIN_CYC,
  parameter int unsigned DIR_HOLD_CYC  = `ASM_DIR_HOLD_CYC,
  parameter int unsigned BLINK_PER_CYC = `ASM_BLINK_PER_CYC,
  parameter int unsigned BRIEF_ON_CYC  = `ASM_BRIEF_ON_CYC
) (
  input  wire logic          CLK,
  input  wire logic          NRST,
  input  wire logic          CFG_LOADED,
  input  wire logic          INT_FAULT,
  input  wire logic [1:0]    SHEAR_PIN_EN,
  input  wire logic [1:0]    TRACK_A,
  input  wire logic [1:0]    TRACK_B,
  input  wire logic [3:0]    PROX_IN,
  input  wire logic [1:0]    OVERSPEED,
  input  wire logic [1:0]    ENC_CONNECTED,
  input  wire logic [1:0]    ENC_EXT_FAULT,
  output asm_axis_out_t [1:0] AXIS_OUT,
  output asm_case_t [1:0]    AXIS_CASE,
  output logic [1:0]         ERR_PUSH,
  output logic [1:0]         DIR_VALID,
  output logic               READY_LED,
  output logic               FAULT_LED,
  output logic [1:0]         AXIS_STATE_LED,
  output logic [1:0]         ENCODER_PORT_LED,
  output logic [3:0]         PROX_INPUT_LED
);

  asm_mon_st_t st_r;
  asm_mon_st_t st_nxt;
  logic [7:0]  raw_all;
  logic [7:0]  act_all;
  logic [1:0]  act_a;
  logic [1:0]  act_b;
  logic [1:0]  act_p;

  // raw inputs: tracks A, tracks B, then the four proximity inputs
  assign raw_all = {PROX_IN, TRACK_B, TRACK_A};

  // one activity detector per input line
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_act
      asm_act_det #(
        .WIN_CYC (ACT_WIN_CYC)
      ) u_act (
        .CLK      (CLK),
        .NRST     (NRST),
        .PULSE_IN (raw_all[gi]),
        .ACTIVE   (act_all[gi])
      );
    end
  endgenerate

  // per-axis activity: the proximity of an axis is active if either switch pulses
  always_comb begin
    for (int i = 0; i < `ASM_AXES; i++) begin
      act_a[i] = act_all[i];
      act_b[i] = act_all[2 + i];
      act_p[i] = act_all[4 + 2 * i] | act_all[5 + 2 * i];
    end
  end

  // plausibility case from track A, track B and proximity activity
  function automatic asm_case_t classify(
    input logic a,
    input logic b,
    input logic p,
    input logic shear_en
  );
    asm_case_t c;
    c = PL_STILL;
    unique case ({a, b, p})
      3'b000: c = PL_STILL;
      3'b001: c = shear_en ? PL_SHEAR_BROKEN : PL_PROX_ONLY;
      3'b010: c = PL_B_ONLY;
      3'b011: c = PL_A_LOST;
      3'b100: c = PL_A_ONLY;
      3'b101: c = PL_B_LOST;
      3'b110: c = PL_PROX_LOST;
      3'b111: c = PL_ROTATE;
    endcase
    return c;
  endfunction

  // table of outputs and diagnostics for one case
  function automatic asm_axis_out_t judge(
    input asm_case_t c,
    input logic      over
  );
    asm_axis_out_t o;
    o          = '0;
    o.speed_ok = 1'b1;
    unique case (c)
      PL_STILL: begin
        o.standstill = 1'b1;
      end
      PL_PROX_ONLY: begin
        o.standstill = 1'b1;
        o.diag_enc   = 1'b1;
      end
      PL_SHEAR_BROKEN: begin
        o.speed_ok  = 1'b0;
        o.diag_enc  = 1'b1;
        o.err_entry = 1'b1;
      end
      PL_B_ONLY, PL_A_ONLY: begin
        o.standstill = 1'b1;
      end
      PL_A_LOST, PL_B_LOST: begin
        o.speed_ok  = ~over;
        o.diag_freq = 1'b1;
        o.err_entry = 1'b1;
      end
      PL_PROX_LOST: begin
        o.speed_ok  = ~over;
        o.diag_prox = 1'b1;
        o.err_entry = 1'b1;
      end
      PL_ROTATE: begin
        o.speed_ok = ~over;
      end
      default: begin
        o.speed_ok = 1'b0;
      end
    endcase
    return o;
  endfunction

  // next state of the whole monitor
  always_comb begin
    logic          flash;
    logic          brief;
    logic          running;
    logic          any_ext;
    logic          ext;
    logic          fault_bits;
    asm_case_t     c;
    asm_axis_out_t o;
    flash      = 1'b0;
    brief      = 1'b0;
    running    = 1'b0;
    any_ext    = 1'b0;
    ext        = 1'b0;
    fault_bits = 1'b0;
    c          = PL_STILL;
    o          = '0;
    st_nxt     = st_r;

    // free-running blink phase shared by the fault, axis state and encoder port indicators
    if (st_r.blink_cnt >= 32'(BLINK_PER_CYC - 1)) begin
      st_nxt.blink_cnt = 32'h0;
    end else begin
      st_nxt.blink_cnt = st_r.blink_cnt + 32'h1;
    end
    flash = st_r.blink_cnt < 32'(BLINK_PER_CYC / 2);
    brief = st_r.blink_cnt < 32'(BRIEF_ON_CYC);

    // system state: load configuration, run, latched safe state
    unique case (st_r.sys)
      SYS_LOAD: begin
        if (INT_FAULT) begin
          st_nxt.sys = SYS_SAFE;
        end else if (CFG_LOADED) begin
          st_nxt.sys = SYS_RUN;
        end
      end
      SYS_RUN: begin
        if (INT_FAULT) begin
          st_nxt.sys = SYS_SAFE;
        end
      end
      SYS_SAFE: begin
        st_nxt.sys = SYS_SAFE;
      end
      default: begin
        st_nxt.sys = SYS_SAFE;
      end
    endcase
    running = (st_r.sys == SYS_RUN) && !INT_FAULT;

    // each axis is evaluated on its own
    for (int i = 0; i < `ASM_AXES; i++) begin
      c = classify(act_a[i], act_b[i], act_p[i], SHEAR_PIN_EN[i]);
      o = judge(c, OVERSPEED[i]);
      ext = ENC_EXT_FAULT[i] | (c == PL_SHEAR_BROKEN);
      if (!running) begin
        o = '0;
      end else if (ENC_EXT_FAULT[i]) begin
        o.standstill = 1'b0;
        o.speed_ok   = 1'b0;
      end
      st_nxt.cls[i]  = c;
      st_nxt.axis[i] = o;

      // one push per entry into an error case or change of error case
      st_nxt.err_push[i] = o.err_entry &&
                           (!st_r.axis[i].err_entry || (c != st_r.cls[i]));

      // direction distrust window after an encoder or internal error
      if (st_nxt.err_push[i] || ENC_EXT_FAULT[i] || INT_FAULT) begin
        st_nxt.dir_cnt[i] = 32'(DIR_HOLD_CYC);
      end else if (st_r.dir_cnt[i] != 32'h0) begin
        st_nxt.dir_cnt[i] = st_r.dir_cnt[i] - 32'h1;
      end
      st_nxt.dir_valid[i] = running && (st_nxt.dir_cnt[i] == 32'h0);

      // axis state indicator
      fault_bits = o.diag_enc | o.diag_prox | o.diag_freq;
      if (!running) begin
        st_nxt.axis_led[i] = 1'b0;
      end else if (fault_bits || ENC_EXT_FAULT[i]) begin
        st_nxt.axis_led[i] = brief;
      end else if (o.standstill) begin
        st_nxt.axis_led[i] = 1'b1;
      end else if (!o.speed_ok) begin
        st_nxt.axis_led[i] = flash;
      end else begin
        st_nxt.axis_led[i] = 1'b0;
      end

      // encoder port indicator
      if (running && ext) begin
        st_nxt.enc_led[i] = flash;
      end else begin
        st_nxt.enc_led[i] = ENC_CONNECTED[i];
      end
      any_ext = any_ext | (running & ext);
    end

    // proximity inputs shown as energised levels
    st_nxt.prox_led = PROX_IN;

    // fault indicator: flash on internal, steady on external
    if (st_r.sys == SYS_SAFE || INT_FAULT) begin
      st_nxt.fault_led = flash;
    end else begin
      st_nxt.fault_led = any_ext;
    end

    // ready only while running without a forced safe state
    st_nxt.ready_led = running && !any_ext;
  end

  // state register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= `ASM_RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign AXIS_OUT         = st_r.axis;
  assign AXIS_CASE        = st_r.cls;
  assign ERR_PUSH         = st_r.err_push;
  assign DIR_VALID        = st_r.dir_valid;
  assign READY_LED        = st_r.ready_led;
  assign FAULT_LED        = st_r.fault_led;
  assign AXIS_STATE_LED   = st_r.axis_led;
  assign ENCODER_PORT_LED = st_r.enc_led;
  assign PROX_INPUT_LED   = st_r.prox_led;

endmodule
`default_nettype wire

// ===== asm_chk_monitor.sv
// assertion checker for the axis speed plausibility monitor
`timescale 1ns/1ps
`default_nettype none
module asm_chk
  import asm_pkg::*;
(
  input wire logic                CLK,
  input wire logic                NRST,
  input wire logic                CFG_LOADED,
  input wire logic [3:0]          PROX_IN,
  input wire logic [1:0]          OVERSPEED,
  input wire asm_axis_out_t [1:0] AXIS_OUT,
  input wire asm_case_t [1:0]     AXIS_CASE,
  input wire logic [1:0]          ERR_PUSH,
  input wire logic [1:0]          DIR_VALID,
  input wire logic                READY_LED,
  input wire logic [1:0]          AXIS_STATE_LED,
  input wire logic [3:0]          PROX_INPUT_LED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // axis one outputs against the plausibility table, then direction, ready and indicator checks
  chk_still_ok: assert property (
    AXIS_OUT[0].standstill |-> AXIS_OUT[0].speed_ok) else $error("standstill without ok");
  chk_rot_speed: assert property (
    READY_LED && AXIS_CASE[0] == PL_ROTATE |-> AXIS_OUT[0].speed_ok == !$past(OVERSPEED[0]))
    else $error("speed ok wrong while rotating");
  chk_enc_diag: assert property (
    READY_LED |-> AXIS_OUT[0].diag_enc == (AXIS_CASE[0] inside {PL_PROX_ONLY, PL_SHEAR_BROKEN}))
    else $error("encoder fault bit wrong");
  chk_shear_stop: assert property (
    AXIS_CASE[0] == PL_SHEAR_BROKEN |-> !AXIS_OUT[0].standstill && !AXIS_OUT[0].speed_ok)
    else $error("broken shear pin not shut down");
  chk_entry_case: assert property (
    READY_LED |-> AXIS_OUT[0].err_entry == (AXIS_CASE[0] inside
      {PL_SHEAR_BROKEN, PL_A_LOST, PL_B_LOST, PL_PROX_LOST})) else $error("error entry wrong");
  chk_freq_diag: assert property (
    READY_LED |-> AXIS_OUT[0].diag_freq == (AXIS_CASE[0] inside {PL_A_LOST, PL_B_LOST}))
    else $error("frequency difference bit wrong");
  chk_prox_diag: assert property (
    READY_LED |-> AXIS_OUT[0].diag_prox == (AXIS_CASE[0] == PL_PROX_LOST))
    else $error("proximity fault bit wrong");
  chk_dir_hold: assert property (
    ERR_PUSH[0] |=> !DIR_VALID[0] [*8]) else $error("direction trusted too soon");
  chk_ready_cfg: assert property (
    READY_LED |-> $past(CFG_LOADED, 2)) else $error("ready before configuration");
  chk_still_led: assert property (
    READY_LED && AXIS_OUT[0].standstill && !AXIS_OUT[0].diag_enc |-> AXIS_STATE_LED[0])
    else $error("axis indicator dark at standstill");
  chk_prox_led: assert property (
    $past(NRST) |-> PROX_INPUT_LED == $past(PROX_IN)) else $error("proximity indicator wrong");
endmodule
bind asm_monitor asm_chk u_chk (.CLK(CLK), .NRST(NRST), .CFG_LOADED(CFG_LOADED),
  .PROX_IN(PROX_IN), .OVERSPEED(OVERSPEED), .AXIS_OUT(AXIS_OUT), .AXIS_CASE(AXIS_CASE),
  .ERR_PUSH(ERR_PUSH), .DIR_VALID(DIR_VALID), .READY_LED(READY_LED),
  .AXIS_STATE_LED(AXIS_STATE_LED), .PROX_INPUT_LED(PROX_INPUT_LED));
`default_nettype wire

// ===== asm_shaft_model.sv
// shaft sensor model: encoder tracks and proximity switches
`timescale 1ns/1ps
`default_nettype none
module asm_shaft_model (
  input  wire logic       CLK,
  input  wire logic       SLOW,
  input  wire logic [1:0] RUN_A,
  input  wire logic [1:0] RUN_B,
  input  wire logic [3:0] RUN_P,
  output logic [1:0]      TRACK_A,
  output logic [1:0]      TRACK_B,
  output logic [3:0]      PROX_IN
);
  logic [1:0] div;
  // idle lines hold still, running lines toggle fast or every fourth edge
  initial begin
    div = 2'h0;
    TRACK_A = 2'h0;
    TRACK_B = 2'h0;
    PROX_IN = 4'h0;
  end
  always @(posedge CLK) begin
    div <= div + 2'h1;
    if (!SLOW || div == 2'h0) begin
      TRACK_A <= TRACK_A ^ RUN_A;
      TRACK_B <= TRACK_B ^ RUN_B;
      PROX_IN <= PROX_IN ^ RUN_P;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench of the axis speed plausibility monitor
`timescale 1ns/1ps
`default_nettype none
module tb
  import asm_pkg::*;
;
  logic CLK, NRST, CFG_LOADED, INT_FAULT, slow, READY_LED, FAULT_LED;
  logic [1:0] SHEAR_PIN_EN, OVERSPEED, ENC_CONNECTED, ENC_EXT_FAULT, run_a, run_b;
  logic [1:0] TRACK_A, TRACK_B, ENCODER_PORT_LED;
  logic [1:0] ERR_PUSH, DIR_VALID, AXIS_STATE_LED;
  logic [3:0] PROX_INPUT_LED;
  logic [3:0] run_p, PROX_IN;
  logic [2:0] c;
  asm_axis_out_t [1:0] AXIS_OUT;
  asm_case_t [1:0] AXIS_CASE;
  int fail_count = 0;
  int total_checks = 0;
  int push_cnt = 0;
  int push_base = 0;

  asm_shaft_model u_shaft (.CLK(CLK), .SLOW(slow), .RUN_A(run_a), .RUN_B(run_b),
    .RUN_P(run_p), .TRACK_A(TRACK_A), .TRACK_B(TRACK_B), .PROX_IN(PROX_IN));
  asm_monitor #(.ACT_WIN_CYC(20), .DIR_HOLD_CYC(50), .BLINK_PER_CYC(16), .BRIEF_ON_CYC(2)) dut (
    .CLK(CLK), .NRST(NRST), .CFG_LOADED(CFG_LOADED), .INT_FAULT(INT_FAULT),
    .SHEAR_PIN_EN(SHEAR_PIN_EN), .TRACK_A(TRACK_A), .TRACK_B(TRACK_B), .PROX_IN(PROX_IN),
    .OVERSPEED(OVERSPEED), .ENC_CONNECTED(ENC_CONNECTED), .ENC_EXT_FAULT(ENC_EXT_FAULT),
    .AXIS_OUT(AXIS_OUT), .AXIS_CASE(AXIS_CASE), .ERR_PUSH(ERR_PUSH), .DIR_VALID(DIR_VALID),
    .READY_LED(READY_LED), .FAULT_LED(FAULT_LED), .AXIS_STATE_LED(AXIS_STATE_LED),
    .ENCODER_PORT_LED(ENCODER_PORT_LED), .PROX_INPUT_LED(PROX_INPUT_LED));

  // error-stack entries of axis one, counted mid-cycle while the pulse stands
  always @(negedge CLK) begin
    if (ERR_PUSH[0] === 1'b1) begin
      push_cnt++;
    end
  end

  // expected case and outputs of one axis for track a, track b, proximity
  function automatic logic [9:0] expect_of(input logic [2:0] k, input logic sh, input logic ov);
    logic [5:0] ok;
    ok = {1'b0, !ov, 4'h0};
    case (k)
      3'h0: return {PL_STILL, 6'h30};
      3'h1: return sh ? {PL_SHEAR_BROKEN, 6'h05} : {PL_PROX_ONLY, 6'h34};
      3'h2: return {PL_B_ONLY, 6'h30};
      3'h3: return {PL_A_LOST, 6'h03 | ok};
      3'h4: return {PL_A_ONLY, 6'h30};
      3'h5: return {PL_B_LOST, 6'h03 | ok};
      3'h6: return {PL_PROX_LOST, 6'h09 | ok};
      default: return {PL_ROTATE, ok};
    endcase
  endfunction

  task automatic cmp_axis(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t axis got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  // activity window of 20 clock cycles plus margin
  task automatic settle();
    repeat (30) @(negedge CLK);
  endtask

  // indicator must be lit part of the time and dark part of the time
  task automatic flash_check(input int sel);
    int on;
    on = 0;
    repeat (32) begin
      @(negedge CLK);
      on += (sel == 1) ? FAULT_LED : (sel == 2) ? AXIS_STATE_LED[0] : ENCODER_PORT_LED[1];
    end
    cmp_bit(on > 0 && on < 32, 1'b1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    #20000;
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    {NRST, CFG_LOADED, INT_FAULT, slow} = 4'h0;
    {SHEAR_PIN_EN, OVERSPEED, ENC_CONNECTED, ENC_EXT_FAULT, run_a, run_b} = 12'h000;
    run_p = 4'h0;
    repeat (4) @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    cmp_bit(READY_LED, 1'b0);
    CFG_LOADED = 1'b1;
    ENC_CONNECTED = 2'h3;
    SHEAR_PIN_EN = 2'h1;
    settle();
    cmp_bit(READY_LED, 1'b1);
    cmp_bit(ENCODER_PORT_LED[1], 1'b1);
    $display("test startup done");
    // every input combination, axis two sees the complement
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      run_a = {~c[2], c[2]};
      run_b = {~c[1], c[1]};
      run_p = {~c[0], 2'h0, c[0]};
      OVERSPEED = {1'b0, c[1]};
      slow = c[0];
      settle();
      cmp_axis({AXIS_CASE[0], AXIS_OUT[0]}, expect_of(c, 1'b1, c[1]));
      cmp_axis({AXIS_CASE[1], AXIS_OUT[1]}, expect_of(~c, 1'b0, 1'b0));
      $display("test combination %0d done", i);
    end
    // axis two at standstill is steady, axis one over the limit flashes
    cmp_bit(AXIS_STATE_LED[1], 1'b1);
    flash_check(2);
    repeat (60) @(negedge CLK);
    cmp_bit(DIR_VALID[0], 1'b1);
    $display("test indicators done");
    // losing track A on a rotating axis one gives one error entry
    push_base = push_cnt;
    run_a = 2'h0;
    settle();
    cmp_axis({AXIS_CASE[0], AXIS_OUT[0]}, expect_of(3'h3, 1'b1, 1'b1));
    cmp_bit(push_cnt == push_base + 1, 1'b1);
    cmp_bit(DIR_VALID[0], 1'b0);
    flash_check(2);
    repeat (60) @(negedge CLK);
    cmp_bit(DIR_VALID[0], 1'b1);
    cmp_bit(push_cnt == push_base + 1, 1'b1);
    $display("test error entry done");
    // external fault at encoder input of axis two
    ENC_EXT_FAULT = 2'h2;
    repeat (4) @(negedge CLK);
    cmp_bit(FAULT_LED, 1'b1);
    cmp_bit(AXIS_OUT[1].speed_ok | AXIS_OUT[1].standstill, 1'b0);
    cmp_bit(READY_LED, 1'b0);
    flash_check(0);
    ENC_EXT_FAULT = 2'h0;
    repeat (4) @(negedge CLK);
    cmp_bit(READY_LED, 1'b1);
    $display("test external fault done");
    // internal fault latches the safe state
    INT_FAULT = 1'b1;
    repeat (4) @(negedge CLK);
    cmp_bit(AXIS_OUT[0].speed_ok | AXIS_OUT[0].standstill, 1'b0);
    cmp_bit(DIR_VALID[0], 1'b0);
    flash_check(1);
    $display("test internal fault done");
    // proximity indicators follow the switch levels once they rest
    run_p = 4'h0;
    repeat (2) @(negedge CLK);
    cmp_axis({6'h00, PROX_INPUT_LED}, {6'h00, PROX_IN});
    $display("test proximity indicators done");
    give_verdict();
  end
endmodule
`default_nettype wire
